/* rtl/asb_pkg.sv */
// package: status register layout, addresses and operation codes
package asb_pkg;
    localparam logic [8:0] ADDR_STATUS_B0 = 9'h003;
    localparam logic [8:0] ADDR_POINTER_B0 = 9'h004;
    localparam logic [8:0] ADDR_STATUS_B2 = 9'h103;
    localparam logic [8:0] ADDR_POINTER_B2 = 9'h104;
    localparam logic [8:0] ADDR_STATUS_B3 = 9'h183;
    localparam logic [8:0] ADDR_POINTER_B3 = 9'h184;
    localparam int BIT_IND_BANK = 7;
    localparam int BIT_DIR_BANK_HI = 6;
    localparam int BIT_DIR_BANK_LO = 5;
    localparam int BIT_WDOG_EXP = 4;
    localparam int BIT_SLEEP_ENT = 3;
    localparam int BIT_NULL = 2;
    localparam int BIT_NIBBLE = 1;
    localparam int BIT_MSB = 0;
    localparam int NIBBLE_W = 4;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] WRITE_KEEP_MASK = 8'h18;
    typedef enum logic [2:0] {
        ASB_OP_NONE = 3'b000,
        ASB_OP_ADD = 3'b001,
        ASB_OP_SUB = 3'b010,
        ASB_OP_LOGIC = 3'b011,
        ASB_OP_ROR = 3'b100,
        ASB_OP_ROL = 3'b101,
        ASB_OP_PASS = 3'b110
    } asb_op_t;
endpackage : asb_pkg

/* rtl/asb_flag_calc.sv */
// flag results of one datapath operation
`timescale 1ns/1ps
module asb_flag_calc (
    input wire asb_pkg::asb_op_t op,
    input wire logic [7:0] opa,
    input wire logic [7:0] opb,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic null_out,
    output logic nibble_out,
    output logic msb_out,
    output logic sets_null,
    output logic sets_carries
);
    import asb_pkg::*;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    always_comb begin
        // subtract adds the complement: carries read as no-borrow
        addend = (op == ASB_OP_SUB) ? ~opb : opb;
        sum = {1'b0, opa} + {1'b0, addend} + {8'h00, op == ASB_OP_SUB};
        low = {1'b0, opa[NIBBLE_W-1:0]} + {1'b0, addend[NIBBLE_W-1:0]}
            + {4'h0, op == ASB_OP_SUB};
        result = opb;
        nibble_out = 1'b0;
        msb_out = 1'b0;
        sets_null = 1'b0;
        sets_carries = 1'b0;
        case (op)
            ASB_OP_ADD, ASB_OP_SUB: begin
                result = sum[7:0];
                nibble_out = low[NIBBLE_W];
                msb_out = sum[8];
                sets_null = 1'b1;
                sets_carries = 1'b1;
            end
            ASB_OP_LOGIC: begin
                result = opa;
                sets_null = 1'b1;
            end
            ASB_OP_ROR: begin
                result = {carry_in, opb[7:1]};
                msb_out = opb[0];
                sets_carries = 1'b1;
            end
            ASB_OP_ROL: begin
                result = {opb[6:0], carry_in};
                msb_out = opb[7];
                sets_carries = 1'b1;
            end
            default: result = opb;
        endcase
        null_out = (result == 8'h00);
    end
endmodule : asb_flag_calc

/* rtl/asb_status_bank.sv */
// status register, bank select and data address former
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - status register writable like any file register
// - flag-updating writes keep computed result flags
// - software cannot write reset-status bits
// - bit 7 picks indirect bank pair
// - bits 6-5 pick direct bank
// - watchdog flag set power-up/clear/sleep, cleared timeout
// - sleep flag set power-up/clear, cleared by sleep
// - null flag follows zero result
// - nibble flag is carry from bit 3
// - msb flag is carry from bit 7
// - subtract adds two's complement, carries invert borrow
// - rotates load msb flag with shifted bit
// - reset gives 0001 1xxx, flags zero here
module asb_status_bank (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [8:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire asb_pkg::asb_op_t OP,
    input wire logic [7:0] OPA,
    input wire logic [7:0] OPB,
    input wire logic OP_VALID,
    output logic [7:0] OP_RESULT,
    input wire logic WDOG_CLEAR,
    input wire logic SLEEP_EXEC,
    input wire logic WDOG_TIMEOUT,
    input wire logic [6:0] DIRECT_OPERAND,
    output logic [8:0] DIRECT_ADDR,
    output logic [8:0] INDIRECT_ADDR,
    output logic [7:0] STATUS_VALUE
);
    import asb_pkg::*;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] pointer_r;
    logic [7:0] pointer_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [7:0] result;
    logic null_f;
    logic nibble_f;
    logic msb_f;
    logic sets_null;
    logic sets_carries;
    logic hit_status;
    logic hit_pointer;
    logic op_go;

    asb_flag_calc u_calc (
        .op(OP),
        .opa(OPA),
        .opb(OPB),
        .carry_in(status_r[BIT_MSB]),
        .result(result),
        .null_out(null_f),
        .nibble_out(nibble_f),
        .msb_out(msb_f),
        .sets_null(sets_null),
        .sets_carries(sets_carries)
    );

    // status is mirrored in every bank at the same low address
    assign hit_status = (ADDR == ADDR_STATUS_B0)
        || (ADDR == ADDR_STATUS_B0 + 9'h080)
        || (ADDR == ADDR_STATUS_B2) || (ADDR == ADDR_STATUS_B3);
    assign hit_pointer = (ADDR == ADDR_POINTER_B0)
        || (ADDR == ADDR_POINTER_B0 + 9'h080)
        || (ADDR == ADDR_POINTER_B2) || (ADDR == ADDR_POINTER_B3);
    assign op_go = OP_VALID && (OP != ASB_OP_NONE);

    always_comb begin
        status_nxt = status_r;
        pointer_nxt = pointer_r;
        // ordinary destination write; reset-status bits held
        if (WR && hit_status) begin
            status_nxt = (WDATA & ~WRITE_KEEP_MASK)
                | (status_r & WRITE_KEEP_MASK);
        end
        if (WR && hit_pointer) begin
            pointer_nxt = WDATA;
        end
        // flag results applied after the write so they override it
        if (op_go && sets_null) begin
            status_nxt[BIT_NULL] = null_f;
        end
        if (op_go && sets_carries) begin
            status_nxt[BIT_MSB] = msb_f;
            if (OP == ASB_OP_ADD || OP == ASB_OP_SUB) begin
                status_nxt[BIT_NIBBLE] = nibble_f;
            end
        end
        // hardware events; timeout wins over a coincident clear
        if (WDOG_CLEAR) begin
            status_nxt[BIT_WDOG_EXP] = 1'b1;
            status_nxt[BIT_SLEEP_ENT] = 1'b1;
        end
        if (SLEEP_EXEC) begin
            status_nxt[BIT_WDOG_EXP] = 1'b1;
            status_nxt[BIT_SLEEP_ENT] = 1'b0;
        end
        if (WDOG_TIMEOUT) begin
            status_nxt[BIT_WDOG_EXP] = 1'b0;
        end
        rdata_nxt = 8'h00;
        if (RD && hit_status) begin
            rdata_nxt = status_r;
        end else if (RD && hit_pointer) begin
            rdata_nxt = pointer_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            status_r <= STATUS_RESET;
            pointer_r <= POINTER_RESET;
            rdata_r <= 8'h00;
        end else begin
            status_r <= status_nxt;
            pointer_r <= pointer_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign OP_RESULT = result;
    assign STATUS_VALUE = status_r;
    assign DIRECT_ADDR = {status_r[BIT_DIR_BANK_HI:BIT_DIR_BANK_LO],
        DIRECT_OPERAND};
    assign INDIRECT_ADDR = {status_r[BIT_IND_BANK], pointer_r};

    a_reset_value: assert property (@(posedge CLK)
        !RESETN |=> status_r == STATUS_RESET)
        else $error("status not at reset value");

    a_sw_write_prot: assert property (@(posedge CLK) disable iff (!RESETN)
        WR && hit_status && !WDOG_CLEAR && !SLEEP_EXEC && !WDOG_TIMEOUT
        |=> status_r[4:3] == $past(status_r[4:3]))
        else $error("reset-status bits written by software");

    a_plain_write: assert property (@(posedge CLK) disable iff (!RESETN)
        WR && hit_status && !op_go
        |=> status_r[7:5] == $past(WDATA[7:5])
            && status_r[2:0] == $past(WDATA[2:0]))
        else $error("status write not stored");

    a_flag_override: assert property (@(posedge CLK) disable iff (!RESETN)
        WR && hit_status && op_go && sets_null
        |=> status_r[BIT_NULL] == $past(null_f))
        else $error("written value beat null flag");

    a_wdog_timeout: assert property (@(posedge CLK) disable iff (!RESETN)
        WDOG_TIMEOUT |=> !status_r[BIT_WDOG_EXP])
        else $error("watchdog flag not cleared");

    a_sleep_enter: assert property (@(posedge CLK) disable iff (!RESETN)
        SLEEP_EXEC && !WDOG_TIMEOUT
        |=> !status_r[BIT_SLEEP_ENT] && status_r[BIT_WDOG_EXP])
        else $error("sleep flags wrong");

    a_add_carry: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_ADD
        |=> status_r[BIT_MSB] == ($past({1'b0, OPA} + {1'b0, OPB}) > 9'h0FF))
        else $error("add carry wrong");

    a_sub_borrow: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_SUB
        |=> status_r[BIT_MSB] == ($past(OPA) >= $past(OPB)))
        else $error("subtract borrow polarity wrong");

    a_indirect_bank: assert property (@(posedge CLK) disable iff (!RESETN)
        WR && hit_pointer
        |=> INDIRECT_ADDR[7:0] == $past(WDATA)
            && INDIRECT_ADDR[8] == $past(status_r[BIT_IND_BANK]))
        else $error("indirect bank wrong");

    sequence s_clear_only;
        WDOG_CLEAR && !SLEEP_EXEC && !WDOG_TIMEOUT;
    endsequence

    sequence s_reset_flags_high;
        status_r[BIT_WDOG_EXP] && status_r[BIT_SLEEP_ENT];
    endsequence

    sequence s_status_write;
        WR && hit_status;
    endsequence

    sequence s_bank_follows;
        DIRECT_ADDR[8:7] == $past(WDATA[6:5])
            && INDIRECT_ADDR[8] == $past(WDATA[7]);
    endsequence

    a_clear_sets: assert property (@(posedge CLK) disable iff (!RESETN)
        s_clear_only |=> s_reset_flags_high)
        else $error("clear did not set reset-status bits");

    a_bank_write: assert property (@(posedge CLK) disable iff (!RESETN)
        s_status_write |=> s_bank_follows)
        else $error("bank bits not taken from write");

    a_bank_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        !(WR && hit_status)
        |=> status_r[7:5] == $past(status_r[7:5]))
        else $error("bank bits changed without write");

    a_pointer_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        !(WR && hit_pointer) |=> pointer_r == $past(pointer_r))
        else $error("pointer changed without write");

    a_read_status: assert property (@(posedge CLK) disable iff (!RESETN)
        RD && hit_status |=> RDATA == $past(status_r))
        else $error("status read data wrong");

    a_read_pointer: assert property (@(posedge CLK) disable iff (!RESETN)
        RD && hit_pointer |=> RDATA == $past(pointer_r))
        else $error("pointer read data wrong");

    a_read_idle: assert property (@(posedge CLK) disable iff (!RESETN)
        !RD |=> RDATA == 8'h00)
        else $error("read data outside read slot");

    a_unmapped_read: assert property (@(posedge CLK) disable iff (!RESETN)
        RD && !hit_status && !hit_pointer |=> RDATA == 8'h00)
        else $error("unmapped read not zero");

    a_reset_pointer: assert property (@(posedge CLK)
        !RESETN |=> pointer_r == POINTER_RESET && RDATA == 8'h00)
        else $error("pointer or read data not reset");

    a_direct_low: assert property (@(posedge CLK) disable iff (!RESETN)
        DIRECT_ADDR[6:0] == DIRECT_OPERAND)
        else $error("direct operand not passed");

    a_quiet_flags: assert property (@(posedge CLK) disable iff (!RESETN)
        !WDOG_CLEAR && !SLEEP_EXEC && !WDOG_TIMEOUT
        |=> status_r[4:3] == $past(status_r[4:3]))
        else $error("reset-status bits moved without event");

    a_timeout_sleep: assert property (@(posedge CLK) disable iff (!RESETN)
        WDOG_TIMEOUT && !SLEEP_EXEC && !WDOG_CLEAR
        |=> status_r[BIT_SLEEP_ENT] == $past(status_r[BIT_SLEEP_ENT]))
        else $error("timeout disturbed sleep flag");

    a_add_nibble: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_ADD
        |=> status_r[BIT_NIBBLE]
            == ($past({1'b0, OPA[3:0]} + {1'b0, OPB[3:0]}) > 5'h0F))
        else $error("add nibble carry wrong");

    a_sub_nibble: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_SUB
        |=> status_r[BIT_NIBBLE] == ($past(OPA[3:0]) >= $past(OPB[3:0])))
        else $error("subtract nibble borrow wrong");

    a_null_flag: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && sets_null
        |=> status_r[BIT_NULL] == ($past(OP_RESULT) == 8'h00))
        else $error("null flag wrong");

    a_ror_carry: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_ROR |=> status_r[BIT_MSB] == $past(OPB[0]))
        else $error("right rotate carry wrong");

    a_rol_carry: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_ROL |=> status_r[BIT_MSB] == $past(OPB[7]))
        else $error("left rotate carry wrong");

    a_ror_result: assert property (@(posedge CLK) disable iff (!RESETN)
        OP == ASB_OP_ROR
        |-> OP_RESULT == {status_r[BIT_MSB], OPB[7:1]})
        else $error("right rotate result wrong");

    a_rol_result: assert property (@(posedge CLK) disable iff (!RESETN)
        OP == ASB_OP_ROL
        |-> OP_RESULT == {OPB[6:0], status_r[BIT_MSB]})
        else $error("left rotate result wrong");

    a_add_result: assert property (@(posedge CLK) disable iff (!RESETN)
        OP == ASB_OP_ADD |-> OP_RESULT == 8'(OPA + OPB))
        else $error("add result wrong");

    a_sub_result: assert property (@(posedge CLK) disable iff (!RESETN)
        OP == ASB_OP_SUB |-> OP_RESULT == 8'(OPA - OPB))
        else $error("subtract result wrong");

    a_carry_override: assert property (@(posedge CLK) disable iff (!RESETN)
        WR && hit_status && op_go && sets_carries
        |=> status_r[BIT_MSB] == $past(msb_f))
        else $error("written value beat carry flag");

    a_rotate_null: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && (OP == ASB_OP_ROR || OP == ASB_OP_ROL)
            && !(WR && hit_status)
        |=> status_r[BIT_NULL] == $past(status_r[BIT_NULL]))
        else $error("rotate disturbed null flag");

    a_pass_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_PASS && !(WR && hit_status)
        |=> status_r[2:0] == $past(status_r[2:0]))
        else $error("pass op disturbed flags");

    a_logic_carry: assert property (@(posedge CLK) disable iff (!RESETN)
        op_go && OP == ASB_OP_LOGIC && !(WR && hit_status)
        |=> status_r[1:0] == $past(status_r[1:0]))
        else $error("logic op disturbed carries");

    a_sleep_clear: assert property (@(posedge CLK) disable iff (!RESETN)
        SLEEP_EXEC && WDOG_CLEAR && !WDOG_TIMEOUT
        |=> !status_r[BIT_SLEEP_ENT])
        else $error("sleep did not win over clear");

    a_timeout_wins: assert property (@(posedge CLK) disable iff (!RESETN)
        WDOG_TIMEOUT && (WDOG_CLEAR || SLEEP_EXEC)
        |=> !status_r[BIT_WDOG_EXP])
        else $error("timeout lost to coincident event");
endmodule : asb_status_bank

/* verif/asb_cpu_model.sv */
// datapath and event source model facing the status bank
`timescale 1ns/1ps
module asb_cpu_model import asb_pkg::*; (
    input wire logic clk,
    output asb_op_t op,
    output logic [7:0] opa,
    output logic [7:0] opb,
    output logic op_valid,
    output logic [2:0] ev
);
    initial begin
        op = ASB_OP_NONE;
        {opa, opb, op_valid, ev} = 20'h00000;
    end
    // software alters status here by flag ops; plain moves come from the bench
    // ev is timeout, sleep, clear; one-cycle pulses
    task automatic run(input asb_op_t o, input logic [7:0] a,
        input logic [7:0] b, input logic [2:0] e);
        @(posedge clk);
        op <= o;
        opa <= a;
        opb <= b;
        op_valid <= (o != ASB_OP_NONE);
        ev <= e;
        @(posedge clk);
        op <= ASB_OP_NONE;
        op_valid <= 1'b0;
        ev <= 3'b000;
        #1;
    endtask : run
endmodule : asb_cpu_model

/* verif/asb_status_bank_bench.sv */
// self-checking bench for the status bank
`timescale 1ns/1ps
module asb_status_bank_bench;
    import asb_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] dop = 7'h55;
    logic [7:0] rdata, res, stat, opa, opb, got;
    logic [8:0] daddr, iaddr;
    asb_op_t op;
    logic opv;
    logic [2:0] ev;
    int err_count = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    asb_cpu_model cpu_u (.clk(clk), .op(op), .opa(opa), .opb(opb),
        .op_valid(opv), .ev(ev));
    asb_status_bank dut_u (.CLK(clk), .RESETN(resetn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .OP(op),
        .OPA(opa), .OPB(opb), .OP_VALID(opv), .OP_RESULT(res),
        .WDOG_CLEAR(ev[0]), .SLEEP_EXEC(ev[1]), .WDOG_TIMEOUT(ev[2]),
        .DIRECT_OPERAND(dop), .DIRECT_ADDR(daddr),
        .INDIRECT_ADDR(iaddr), .STATUS_VALUE(stat));
    task automatic check(input logic [8:0] g, input logic [8:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : check
    task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [8:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
    endtask : rd_reg
    // result is combinational, so it is caught while the op stands
    task automatic op_chk(input asb_op_t o, input logic [7:0] a,
        input logic [7:0] b, input logic [2:0] f, input logic [7:0] r);
        fork
            cpu_u.run(o, a, b, 3'b000);
            begin
                @(posedge clk);
                #1;
                got = res;
            end
        join
        check({1'b0, got}, {1'b0, r});
        check({6'h00, stat[2:0]}, {6'h00, f});
    endtask : op_chk
    task automatic ev_chk(input logic [2:0] e, input logic [1:0] f);
        cpu_u.run(ASB_OP_NONE, 8'h00, 8'h00, e);
        check({7'h00, stat[4:3]}, {7'h00, f});
    endtask : ev_chk
    task automatic summarize();
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #20000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(ADDR_STATUS_B0);
        check({1'b0, got}, {1'b0, STATUS_RESET});
        rd_reg(ADDR_POINTER_B2);
        check({1'b0, got}, {1'b0, POINTER_RESET});
        wr_reg(ADDR_STATUS_B3, 8'hE7);
        check({1'b0, stat}, 9'h0FF);
        wr_reg(ADDR_STATUS_B2, 8'h00);
        rd_reg(ADDR_STATUS_B2);
        check({1'b0, got}, 9'h018);
        // unmapped place: reads zero, write lost
        wr_reg(9'h105, 8'hFF);
        rd_reg(9'h105);
        check({got, stat[0]}, 9'h000);
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_STATUS_B0, {1'b0, i[1:0], 5'h00});
            check(daddr, {i[1:0], 7'h55});
        end
        wr_reg(ADDR_POINTER_B3, 8'hA5);
        wr_reg(ADDR_STATUS_B3, 8'h80);
        check(iaddr, 9'h1A5);
        wr_reg(ADDR_POINTER_B0, 8'h3C);
        wr_reg(ADDR_STATUS_B0, 8'h00);
        check(iaddr, 9'h03C);
        op_chk(ASB_OP_ADD, 8'h0F, 8'h01, 3'b010, 8'h10);
        op_chk(ASB_OP_ADD, 8'hFF, 8'h01, 3'b111, 8'h00);
        op_chk(ASB_OP_ADD, 8'h70, 8'h10, 3'b000, 8'h80);
        op_chk(ASB_OP_SUB, 8'h05, 8'h05, 3'b111, 8'h00);
        op_chk(ASB_OP_LOGIC, 8'h5A, 8'h00, 3'b011, 8'h5A);
        op_chk(ASB_OP_ROR, 8'h00, 8'h02, 3'b010, 8'h81);
        op_chk(ASB_OP_ROL, 8'h00, 8'h80, 3'b011, 8'h00);
        // flag op and write land on the same edge
        fork
            wr_reg(ADDR_STATUS_B2, 8'h07);
            cpu_u.run(ASB_OP_ADD, 8'h01, 8'h01, 3'b000);
        join
        check({1'b0, stat}, 9'h018);
        ev_chk(3'b010, 2'b10);
        ev_chk(3'b100, 2'b00);
        ev_chk(3'b001, 2'b11);
        summarize();
    end
endmodule : asb_status_bank_bench
